/* File: pkg/ddc_defines.svh */
// constants for the ddr command and control input stage
// assumes inclusion by the package, the assertions and the design file only
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
`define DDC_DQ_W 16
`define DDC_DM_W 2
`define DDC_ADDR_W 13
`define DDC_BANKS 4
`define DDC_A_PRE_ALL 10
`define DDC_BL_LSB 0
`define DDC_BL_MSB 2
`define DDC_BL_RST 3'h1
`define DDC_RD_LAT 3
`define DDC_CNT_W 4
`endif

/* File: pkg/ddc_pkg.sv */
// types shared by the ddr command and control input stage
// assumes ddc_defines.svh is on the include path
`include "ddc_defines.svh"
package ddc_pkg;
  // decoded command kinds
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD, CMD_BURST_STOP
  } ddc_cmd_t;
  // power states of the device
  typedef enum logic [1:0] {
    PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
  } ddc_pwr_t;
  // one registered command with its operands
  typedef struct packed {
    ddc_cmd_t kind;
    logic [1:0] bank;
    logic [`DDC_ADDR_W-1:0] addr;
    logic auto_pre;
    logic pre_all;
    logic ext_mode;
    ddc_pwr_t pwr;
  } ddc_cmd_word_t;
  // one write beat pair with byte enables
  typedef struct packed {
    logic valid;
    logic [`DDC_DQ_W-1:0] rise;
    logic [`DDC_DQ_W-1:0] fall;
    logic [`DDC_DM_W-1:0] ben_rise;
    logic [`DDC_DM_W-1:0] ben_fall;
  } ddc_wbeat_t;
  // one read beat pair, rise then fall crossing
  typedef struct packed {
    logic [`DDC_DQ_W-1:0] rise;
    logic [`DDC_DQ_W-1:0] fall;
  } ddc_rbeat_t;
endpackage : ddc_pkg

/* File: tb/ddc_ctl_model.sv */
// controller model: link clock, commands and write beats
// assumes the bench calls send only after reset is over
`timescale 1ns/1ps
`default_nettype none
module ddc_ctl_model (
  output logic diff_clock_pair,
  output logic clock_gate_in,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] bank_select,
  output logic [12:0] addr_in,
  output logic [15:0] wr_dq_rise,
  output logic [15:0] wr_dq_fall,
  output logic [1:0] write_byte_mask_rise,
  output logic [1:0] write_byte_mask_fall
);
  logic [3:0] cw;
  logic [35:0] wd;
  assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = cw;
  assign {wr_dq_rise, wr_dq_fall, write_byte_mask_rise,
    write_byte_mask_fall} = wd;
  // free link clock, gate high, deselected at start
  initial begin
    {diff_clock_pair, clock_gate_in, cw, wd} = {2'h1, 4'hF, 36'h0};
    {bank_select, addr_in} = '0;
    forever #80 diff_clock_pair = ~diff_clock_pair;
  end
  // fresh write beats and masks every link cycle
  always @(posedge diff_clock_pair) #1 wd <= 36'({$urandom, $urandom});
  // one command beside gate level g, then deselect
  task automatic send(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic g);
    @(posedge diff_clock_pair) #1;
    cw = c;
    {bank_select, addr_in} = {b, a};
    clock_gate_in = g;
    @(posedge diff_clock_pair) #1;
    cw = 4'hF;
  endtask : send
endmodule : ddc_ctl_model
`default_nettype wire

/* File: tb/ddc_ctrl_in_bench.sv */
// bench for the ddr command input stage with a controller model
// assumes the model drives every command and gate input through send
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_in_bench import ddc_pkg::*;;
  logic sys_clk, rst_n, diff_clock_pair, clock_gate_in, chip_select_n;
  logic row_strobe_n, column_strobe_n, write_strobe_n, got;
  logic [1:0] bank_select, write_byte_mask_rise, write_byte_mask_fall, b;
  logic [12:0] addr_in, a;
  logic [15:0] wr_dq_rise, wr_dq_fall;
  ddc_rbeat_t rd_core_data, rd_dq_out;
  ddc_wbeat_t wr_beat;
  ddc_cmd_word_t core_cmd;
  logic rd_dq_oe_n, int_clk_en, cmd_buf_en, clk_buf_en;
  logic core_cmd_valid, core_self_ref;
  logic [3:0] c;
  logic [3:0] ops [5] = '{4'h3, 4'h4, 4'h5, 4'h2, 4'h0};
  logic [3:0] quiet [3] = '{4'hB, 4'h7, 4'hC};
  int n_fail = 0;
  int n_tests = 0;
  ddc_ctl_model u_ctl (.*);
  ddc_ctrl_in dut_u (.*);
  // core clock and fresh core read data each link cycle
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge diff_clock_pair) #1 rd_core_data <= ddc_rbeat_t'($urandom);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for one command word from the core side
  task automatic wait_cmd();
    got = 1'b0;
    for (int k = 0; k < 60 && !got; k++) begin
      @(posedge sys_clk) #1;
      got = core_cmd_valid;
    end
  endtask : wait_cmd
  task automatic power(input logic g, input ddc_pwr_t p);
    u_ctl.send(4'hF, 2'h0, 13'h0, g);
    wait_cmd();
    #100;
    check(core_cmd.pwr, p);
  endtask : power
  function automatic ddc_cmd_t kind_of(input logic [3:0] op);
    case (op)
      4'h3: return CMD_ACTIVATE;
      4'h4: return CMD_WRITE;
      4'h5: return CMD_READ;
      4'h2: return CMD_PRECHARGE;
      default: return CMD_MODE_LOAD;
    endcase
  endfunction : kind_of
  task automatic close_out();
    $display("tests %0d, failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // cut a hang short
  initial begin
    #200us;
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(55928));
    rst_n = 1'b0;
    repeat (4) @(posedge diff_clock_pair);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge diff_clock_pair);
    // activate, write, read, precharge and mode load with random bank and address
    for (int i = 0; i < 25; i++) begin
      c = ops[i % 5];
      b = 2'($urandom);
      a = 13'($urandom);
      if (c == 4'h0) b[1] = 1'b1; // keeps the burst setting
      u_ctl.send(c, b, a, 1'b1);
      wait_cmd();
      check(got, 1'b1);
      check(core_cmd.kind, kind_of(c));
      check(core_cmd.bank, b);
      check(core_cmd.addr, a);
      if (c == 4'h2) check(core_cmd.pre_all, a[10]);
      if (c[3:1] == 3'h2) check(core_cmd.auto_pre, a[10]);
      if (c == 4'h0) check(core_cmd.ext_mode, b[0]);
    end
    // deselected, no-op and deselected write give nothing
    foreach (quiet[i]) begin
      u_ctl.send(quiet[i], 2'h0, 13'h0, 1'b1);
      wait_cmd();
      check(got, 1'b0);
    end
    // row open: active power-down, then wake
    u_ctl.send(4'h3, 2'h1, 13'h0, 1'b1);
    wait_cmd();
    power(1'b0, PWR_ACT_PD);
    check(cmd_buf_en, 1'b0);
    check(clk_buf_en, 1'b1);
    power(1'b1, PWR_ON);
    // all rows closed: precharge power-down
    u_ctl.send(4'h2, 2'h0, 13'h0400, 1'b1);
    wait_cmd();
    power(1'b0, PWR_PRE_PD);
    power(1'b1, PWR_ON);
    // refresh with gate low enters self refresh
    u_ctl.send(4'h1, 2'h0, 13'h0, 1'b0);
    wait_cmd();
    #100;
    check(core_cmd.pwr, PWR_SELF_REF);
    check(clk_buf_en, 1'b0);
    check(core_self_ref, 1'b1);
    power(1'b1, PWR_ON);
    check(core_self_ref, 1'b0);
    close_out();
  end
endmodule : ddc_ctrl_in_bench
bind ddc_ctrl_in ddc_ctrl_in_sva #(.RD_LAT(RD_LAT)) chk_u (.*);
`default_nettype wire

/* File: tb/ddc_ctrl_in_sva.sv */
// assertions on the ports of the ddr command input stage
// assumes a free link clock and one shared sync reset
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_ctrl_in_sva
  import ddc_pkg::*;
#(
  parameter int RD_LAT = `DDC_RD_LAT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic diff_clock_pair,
  input wire logic clock_gate_in,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] wr_dq_rise,
  input wire logic [1:0] write_byte_mask_rise,
  input wire logic [1:0] write_byte_mask_fall,
  input wire ddc_rbeat_t rd_core_data,
  input wire ddc_rbeat_t rd_dq_out,
  input wire logic rd_dq_oe_n,
  input wire ddc_wbeat_t wr_beat,
  input wire logic int_clk_en,
  input wire logic cmd_buf_en,
  input wire logic clk_buf_en,
  input wire logic core_cmd_valid
);
  localparam int RD_DLY = RD_LAT + 2;
  // writes and reads the device takes on this link edge
  wire take = cmd_buf_en && clock_gate_in && !chip_select_n;
  wire wr_c = take && row_strobe_n && !column_strobe_n && !write_strobe_n;
  wire rd_c = take && row_strobe_n && !column_strobe_n && write_strobe_n;

  oe_gate_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) !clock_gate_in |-> rd_dq_oe_n)
    else $error("output on with gate low");
  clk_en_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n)
    $past(rst_n, 3) |-> int_clk_en == $past(clock_gate_in))
    else $error("clock enable wrong");
  pd_in_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) cmd_buf_en && !clock_gate_in |=> !cmd_buf_en)
    else $error("no power-down entry");
  pd_out_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) $past(rst_n, 3) && !cmd_buf_en && clk_buf_en
    && clock_gate_in |-> ##[1:2] cmd_buf_en) else $error("no wake");
  wr_beat_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) wr_c |-> ##2 (wr_beat.valid
    && wr_beat.rise == $past(wr_dq_rise)
    && wr_beat.ben_rise == ~$past(write_byte_mask_rise)
    && wr_beat.ben_fall == ~$past(write_byte_mask_fall)))
    else $error("write beat wrong");
  beat_src_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) wr_beat.valid |-> $past(wr_c, 2))
    else $error("beat without write");
  rd_data_a: assert property (@(posedge diff_clock_pair)
    disable iff (!rst_n) rd_c |-> ##RD_DLY (!rd_dq_oe_n
    && rd_dq_out == $past(rd_core_data))) else $error("read pair wrong");
  valid_pulse_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) core_cmd_valid |=> !core_cmd_valid)
    else $error("command valid held");
endmodule : ddc_ctrl_in_sva
`default_nettype wire

/* File: verilog/ddc_ctrl_in.sv */
// command and control input stage of a four-bank ddr dram
// assumes a controller on the link clock and a core on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_ctrl_in
  import ddc_pkg::*;
#(
  parameter int RD_LAT = `DDC_RD_LAT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic diff_clock_pair,
  input wire logic clock_gate_in,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] bank_select,
  input wire logic [`DDC_ADDR_W-1:0] addr_in,
  input wire logic [`DDC_DQ_W-1:0] wr_dq_rise,
  input wire logic [`DDC_DQ_W-1:0] wr_dq_fall,
  input wire logic [`DDC_DM_W-1:0] write_byte_mask_rise,
  input wire logic [`DDC_DM_W-1:0] write_byte_mask_fall,
  input wire ddc_rbeat_t rd_core_data,
  output ddc_rbeat_t rd_dq_out,
  output logic rd_dq_oe_n,
  output ddc_wbeat_t wr_beat,
  output logic int_clk_en,
  output logic cmd_buf_en,
  output logic clk_buf_en,
  output logic core_cmd_valid,
  output ddc_cmd_word_t core_cmd,
  output logic core_self_ref
);

  // link domain state
  typedef struct packed {
    logic [1:0] rst_s;
    logic cke_q;
    ddc_pwr_t pwr;
    logic [`DDC_BANKS-1:0] bank_open;
    logic [2:0] bl_code;
    logic [`DDC_CNT_W-1:0] wr_left;
    logic [`DDC_CNT_W-1:0] rd_cnt;
    logic tgl;
    ddc_cmd_word_t word;
    ddc_wbeat_t wbeat;
    ddc_rbeat_t rbeat;
    logic int_clk;
    logic cmd_buf;
    logic clk_buf;
  } ddc_link_t;

  // core domain state
  typedef struct packed {
    logic [2:0] tg;
    logic [1:0] sr_s;
    logic valid;
    ddc_cmd_word_t cmd;
    logic sr;
  } ddc_core_t;

  ddc_link_t l;
  ddc_link_t next_l;
  ddc_core_t c;
  ddc_core_t next_c;
  logic sr_q;
  logic sr_entry;
  logic rd_drive;
  logic lrst_n;

  // strobe decode, chip select high masks all
  function automatic ddc_cmd_t decode(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    ddc_cmd_t k;
    k = CMD_DESELECT;
    if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: k = CMD_NOP;
        3'h3: k = CMD_ACTIVATE;
        3'h5: k = CMD_READ;
        3'h4: k = CMD_WRITE;
        3'h2: k = CMD_PRECHARGE;
        3'h1: k = CMD_REFRESH;
        3'h0: k = CMD_MODE_LOAD;
        3'h6: k = CMD_BURST_STOP;
      endcase
    end
    return k;
  endfunction : decode

  // link cycles per burst from the burst length code
  function automatic logic [`DDC_CNT_W-1:0] bl_cycles(input logic [2:0] code);
    logic [`DDC_CNT_W-1:0] n;
    unique case (code)
      3'h1: n = `DDC_CNT_W'(1);
      3'h2: n = `DDC_CNT_W'(2);
      default: n = `DDC_CNT_W'(4);
    endcase
    return n;
  endfunction : bl_cycles

  assign lrst_n = l.rst_s[1];
  assign rd_drive = (l.rd_cnt != '0) && (l.rd_cnt <= bl_cycles(l.bl_code));

  // link side: command decode, bank and power tracking
  always_comb begin
    ddc_cmd_t k;
    logic [`DDC_CNT_W-1:0] blc;
    k = CMD_DESELECT;
    blc = bl_cycles(l.bl_code);
    next_l = l;
    sr_entry = 1'b0;
    next_l.rst_s = {l.rst_s[0], 1'b1};
    next_l.cke_q = clock_gate_in;
    // command buffer off in power-down, clock buffer off only in self refresh, commands not seen
    if (l.pwr == PWR_ON) begin
      k = decode(chip_select_n, row_strobe_n, column_strobe_n,
                 write_strobe_n);
    end
    next_l.wbeat.valid = 1'b0;
    next_l.wbeat.ben_rise = '0;
    next_l.wbeat.ben_fall = '0;
    if (l.wr_left != '0) begin
      next_l.wr_left = l.wr_left - `DDC_CNT_W'(1);
      next_l.wbeat.valid = 1'b1;
      next_l.wbeat.rise = wr_dq_rise;
      next_l.wbeat.fall = wr_dq_fall;
      next_l.wbeat.ben_rise = ~write_byte_mask_rise;
      next_l.wbeat.ben_fall = ~write_byte_mask_fall;
    end
    if (l.rd_cnt != '0) begin
      next_l.rd_cnt = l.rd_cnt - `DDC_CNT_W'(1);
    end
    // read pair, mask inputs not looked at here
    if (rd_drive) begin
      next_l.rbeat = rd_core_data;
    end
    unique case (l.pwr)
      PWR_ON: begin
        if (!clock_gate_in && l.cke_q) begin
          if (k == CMD_REFRESH && l.bank_open == '0) begin
            sr_entry = 1'b1;
            next_l.pwr = PWR_SELF_REF;
          end else if (l.bank_open != '0) begin
            next_l.pwr = PWR_ACT_PD;
          end else begin
            next_l.pwr = PWR_PRE_PD;
          end
        end else if (clock_gate_in && k != CMD_DESELECT && k != CMD_NOP) begin
          next_l.tgl = ~l.tgl;
          next_l.word.kind = k;
          next_l.word.bank = bank_select;
          next_l.word.addr = addr_in;
          next_l.word.auto_pre = addr_in[`DDC_A_PRE_ALL];
          next_l.word.pre_all = addr_in[`DDC_A_PRE_ALL];
          next_l.word.ext_mode = bank_select[0];
          unique case (k)
            CMD_ACTIVATE: next_l.bank_open[bank_select] = 1'b1;
            CMD_PRECHARGE: begin
              if (addr_in[`DDC_A_PRE_ALL]) begin
                next_l.bank_open = '0;
              end else begin
                next_l.bank_open[bank_select] = 1'b0;
              end
            end
            CMD_WRITE: begin
              next_l.wr_left = blc;
              if (addr_in[`DDC_A_PRE_ALL]) begin
                next_l.bank_open[bank_select] = 1'b0;
              end
            end
            CMD_READ: begin
              next_l.rd_cnt = `DDC_CNT_W'(RD_LAT) + blc;
              if (addr_in[`DDC_A_PRE_ALL]) begin
                next_l.bank_open[bank_select] = 1'b0;
              end
            end
            CMD_BURST_STOP: begin
              next_l.wr_left = '0;
              next_l.rd_cnt = '0;
            end
            CMD_MODE_LOAD: begin
              if (bank_select == 2'h0) begin
                next_l.bl_code = addr_in[`DDC_BL_MSB:`DDC_BL_LSB];
              end
            end
            default: ; // refresh keeps bank state
          endcase
        end
        // no-op and deselect fall through unchanged
      end
      PWR_PRE_PD, PWR_ACT_PD: begin
        if (clock_gate_in) begin
          next_l.pwr = PWR_ON;
        end
      end
      PWR_SELF_REF: begin
        if (!sr_q) begin
          next_l.pwr = PWR_ON;
        end
      end
    endcase
    // power state changes also reach the core
    if (next_l.pwr != l.pwr) begin
      next_l.tgl = ~l.tgl;
    end
    next_l.word.pwr = next_l.pwr;
    next_l.int_clk = clock_gate_in;
    next_l.cmd_buf = next_l.pwr == PWR_ON;
    next_l.clk_buf = next_l.pwr != PWR_SELF_REF;
    if (!lrst_n) begin
      next_l = '0;
      next_l.rst_s = {l.rst_s[0], 1'b1}; // keep shifting so release lands
      next_l.bl_code = `DDC_BL_RST;
      next_l.pwr = PWR_ON;
    end
  end

  // link registers on the rising crossing
  always_ff @(posedge diff_clock_pair) begin
    if (!rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // self refresh flag, gate high clears it with no clock
  always_ff @(posedge diff_clock_pair or posedge clock_gate_in) begin
    if (clock_gate_in) begin
      sr_q <= 1'b0;
    end else if (!lrst_n) begin
      sr_q <= 1'b0;
    end else if (sr_entry) begin
      sr_q <= 1'b1;
    end
  end

  // read drivers, gate low disables with no clock
  always_ff @(posedge diff_clock_pair or negedge clock_gate_in) begin
    if (!clock_gate_in) begin
      rd_dq_oe_n <= 1'b1;
    end else if (!lrst_n) begin
      rd_dq_oe_n <= 1'b1;
    end else begin
      rd_dq_oe_n <= ~rd_drive;
    end
  end

  // core side: toggle sync and word capture
  always_comb begin
    next_c = c;
    next_c.tg = {c.tg[1:0], l.tgl};
    next_c.sr_s = {c.sr_s[0], sr_q};
    next_c.sr = c.sr_s[1];
    next_c.valid = c.tg[2] ^ c.tg[1];
    if (c.tg[2] ^ c.tg[1]) begin
      next_c.cmd = l.word; // word held stable since the toggle
    end
    if (!rst_n) begin
      next_c = '0;
    end
  end

  // core registers
  always_ff @(posedge sys_clk) begin
    c <= next_c;
  end

  // outputs straight from flops
  assign rd_dq_out = l.rbeat;
  assign wr_beat = l.wbeat;
  assign int_clk_en = l.int_clk;
  assign cmd_buf_en = l.cmd_buf;
  assign clk_buf_en = l.clk_buf;
  assign core_cmd_valid = c.valid;
  assign core_cmd = c.cmd;
  assign core_self_ref = c.sr;

endmodule : ddc_ctrl_in
`default_nettype wire
